// ==== verilog/prot_defs.svh ====
// constants of the protection supervisor: register map, fields, defaults, timing
// assumes inclusion by bare name from the detector, supervisor and bench modules
`ifndef PROT_DEFS_SVH
`define PROT_DEFS_SVH
// register indices on the plain register port
`define A_STALL_SEL 5'h00
`define A_DEC_LVL 5'h01
`define A_RUN_LVL 5'h02
`define A_RUN_TIME 5'h03
`define A_OL_SEL 5'h04
`define A_OL_ACT 5'h05
`define A_AVR 5'h06
`define A_PHASE_EN 5'h07
`define A_OT_CFG 5'h08
`define A_OT_LVL 5'h09
`define A_OT_TIME 5'h0a
`define A_LT_CFG 5'h0b
`define A_LT_LVL 5'h0c
`define A_LT_TIME 5'h0d
`define A_RELAY_FN 5'h0e
`define A_CTRL_MODE 5'h0f
`define A_CMD 5'h10
`define A_STATUS 5'h11
`define A_THERMAL 5'h12
// field positions
`define SS_DEC_OFF 1
`define SS_RUN_OFF 2
`define SS_RUN_DEC2 3
`define OLS_EN 0
`define OLS_HOT 1
`define OLS_INV 2
// reset values
`define RST_STALL_SEL 4'h0
`define RST_RUN_LVL 8'h96
`define RST_RUN_TIME 7'h64
`define RST_OT_LVL 9'h096
`define RST_LT_LVL 9'h01e
`define RST_DET_TIME 7'h01
// deceleration stall defaults in volts
`define DEC_200_SMALL 10'h18b
`define DEC_200_BIG 10'h181
`define DEC_400_LOWIN 10'h2a8
`define DEC_400_SMALL 10'h316
`define DEC_400_BIG 10'h302
// thresholds in percent
`define RUN_HYST_PCT 8'h02
`define IPL_MIN_PCT 9'h01e
`define OPL_MIN_PCT 9'h00a
`define OL_PICK_PCT 9'h064
`define OL_REL_PCT 9'h064
// thermal limits in milliseconds of overload
`define OL_TH_COLD 16'hc350
`define OL_TH_HOT 16'h61a8
// relay function codes
`define RLY_OVER_TQ 5'h0c
`define RLY_LOW_TQ 5'h19
// timing
`define CLK_NS 10
`define MS_NS 1000000
`define MS_PER_TENTH 14'h0064
`endif

// ==== verilog/prot_pkg.sv ====
// types of the protection supervisor
// assumes prot_defs.svh on the include path
package prot_pkg;
  typedef enum logic [1:0] {
    vf_mode = 2'h0,
    vf_encoder_feedback = 2'h1,
    sensorless_vector_mode = 2'h2,
    sensor_vector_mode = 2'h3
  } ctrl_mode_t;
  typedef enum logic [1:0] {
    det_off = 2'h0,
    det_at_freq = 2'h1,
    det_running = 2'h2
  } det_sel_t;
  typedef enum logic [1:0] {
    act_decel = 2'h0,
    act_warn = 2'h1,
    act_coast = 2'h2
  } det_act_t;
  typedef enum logic [1:0] {
    rs_idle = 2'h0,
    rs_timing = 2'h1,
    rs_reduce = 2'h3
  } run_st_t;
endpackage : prot_pkg

// ==== verilog/torque_detect.sv ====
// over- or low-torque detector: level compare held for a time in tenths of a second
// assumes a one-cycle millisecond tick from the supervisor
`timescale 1ns/1ps
`default_nettype none
`include "prot_defs.svh"
module torque_detect import prot_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // timing and drive state
  input wire logic ms_tick,
  input wire logic running,
  input wire logic at_freq,
  // setup
  input wire logic under,
  input wire logic [1:0] sel,
  input wire logic [8:0] level,
  input wire logic [6:0] tenths,
  // measurement and result
  input wire logic [8:0] meas,
  output logic det_q
);
  logic armed;
  logic beyond;
  logic [13:0] limit;
  logic [13:0] cnt_q;

  always_comb begin
    unique case (sel)
      det_at_freq: armed = running && at_freq;
      det_running: armed = running;
      default: armed = 1'b0;
    endcase
  end
  assign beyond = armed && (under ? (meas < level) : (meas > level));
  assign limit = 14'(tenths) * `MS_PER_TENTH;

  // restarts whenever the condition clears
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 14'h0000;
      det_q <= 1'b0;
    end else if (!beyond) begin
      cnt_q <= 14'h0000;
      det_q <= 1'b0;
    end else begin
      if (ms_tick && cnt_q < limit) begin
        cnt_q <= cnt_q + 14'h0001;
      end
      det_q <= cnt_q >= limit;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  det_cause_a: assert property ($rose(det_q) |-> $past(beyond) && $past(cnt_q) >= $past(limit))
    else $error("torque detection without full detection time");
  det_drop_a: assert property (!beyond |=> !det_q)
    else $error("torque detection held after condition cleared");
endmodule : torque_detect
`default_nettype wire

// ==== verilog/prot_supervisor.sv ====
// protection supervisor of a motor inverter: stall hold, overload, phase loss, torque
// assumes measurements and ramp state come from logic on mclk; ext_reset_n is a pin
//
// How it works
// - decelerating with stall enabled, hold ramp while bus voltage above level.
// - deceleration stall level resets to a default picked by model straps.
// - running stall acts only in volts-per-hertz modes, never in vector modes.
// - current above running level past detection time reduces frequency, decel 1/2.
// - reduction ends once current falls to running level minus two percent.
// - overload field: enable, hot start, inverter-duty curve, bit3 unused.
// - thermal value starts fresh at every power-up.
// - overload action 0 blocks output, flags overload until fault reset.
// - overload action 1 keeps running, flags overload until current drops.
// - regulation setting 0 compensates output voltage, 1 follows input.
// - enabled input phase loss faults, drives fault contact, coasts.
// - input phase loss ignored below thirty percent rated current.
// - enabled output phase loss faults, drives fault contact, coasts.
// - output phase loss ignored below ten percent rated current.
// - over-torque select: off, after set frequency, whenever running.
// - over-torque action: decelerate to stop, warn, coast to stop.
// - over-torque level 0 to 300 percent, time 0.0 to 10.0 s.
// - low-torque select: off, after set frequency, whenever running.
// - low-torque action: decelerate to stop, warn, coast to stop.
// - low-torque level 0 to 300 percent, time 0.0 to 10.0 s.
// - torque levels use rated current in volts-per-hertz, rated torque in vector.
// - relay function codes 12 and 25 output over- and low-torque states.
`timescale 1ns/1ps
`default_nettype none
`include "prot_defs.svh"
module prot_supervisor import prot_pkg::*; #(
  parameter int unsigned MS_CYC = `MS_NS / `CLK_NS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // model straps, static
  input wire logic strap_400v,
  input wire logic strap_vin_hi,
  input wire logic strap_big,
  // reset terminal pin
  input wire logic ext_reset_n,
  // measurements and ramp state
  input wire logic [9:0] bus_volt,
  input wire logic [8:0] cur_pct,
  input wire logic [8:0] trq_pct,
  input wire logic running,
  input wire logic decelerating,
  input wire logic at_freq,
  input wire logic low_speed,
  input wire logic in_phase_lost,
  input wire logic out_phase_lost,
  // ramp commands
  output logic ramp_hold_q,
  output logic ramp_reduce_q,
  output logic use_decel2_q,
  output logic out_block_q,
  output logic coast_stop_q,
  output logic decel_stop_q,
  // indications
  output logic fault_contact_q,
  output logic warn_q,
  output logic motor_overload_fault_q,
  output logic input_phase_loss_fault_q,
  output logic output_phase_loss_fault_q,
  output logic output_voltage_regulation_q,
  output logic relay1_q,
  output logic relay2_q
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [3:0] stall_sel_q, ol_sel_q, ot_cfg_q, lt_cfg_q;
  logic [9:0] dec_lvl_q;
  logic [7:0] run_lvl_q;
  logic [6:0] run_time_q, ot_time_q, lt_time_q;
  logic [8:0] ot_lvl_q, lt_lvl_q;
  logic ol_act_q, avr_off_q, ipl_en_q, opl_en_q, init_q, sw_reset_q;
  logic [4:0] rly1_fn_q, rly2_fn_q;
  ctrl_mode_t mode_q;
  logic [15:0] th_q;
  logic ot_det, lt_det;

  function automatic logic wr_at(input logic [4:0] a);
    wr_at = reg_wr && reg_addr == a;
  endfunction : wr_at

  function automatic logic relay_fn(input logic [4:0] fn, input logic ot, input logic lt);
    relay_fn = (fn == `RLY_OVER_TQ && ot) || (fn == `RLY_LOW_TQ && lt);
  endfunction : relay_fn

  // straps are caught on the first edge after release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      init_q <= 1'b0;
      dec_lvl_q <= 10'h000;
    end else begin
      init_q <= 1'b1;
      if (!init_q) begin
        if (!strap_400v) begin
          dec_lvl_q <= strap_big ? `DEC_200_BIG : `DEC_200_SMALL;
        end else if (!strap_vin_hi) begin
          dec_lvl_q <= `DEC_400_LOWIN;
        end else begin
          dec_lvl_q <= strap_big ? `DEC_400_BIG : `DEC_400_SMALL;
        end
      end else if (wr_at(`A_DEC_LVL)) begin
        dec_lvl_q <= reg_wdata[9:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stall_sel_q <= `RST_STALL_SEL;
      run_lvl_q <= `RST_RUN_LVL;
      run_time_q <= `RST_RUN_TIME;
      ol_sel_q <= 4'h1;
      ol_act_q <= 1'b0;
      avr_off_q <= 1'b0;
      ipl_en_q <= 1'b1;
      opl_en_q <= 1'b1;
      ot_cfg_q <= 4'h0;
      lt_cfg_q <= 4'h0;
      ot_lvl_q <= `RST_OT_LVL;
      lt_lvl_q <= `RST_LT_LVL;
      ot_time_q <= `RST_DET_TIME;
      lt_time_q <= `RST_DET_TIME;
      rly1_fn_q <= 5'h00;
      rly2_fn_q <= 5'h00;
      mode_q <= vf_mode;
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= wr_at(`A_CMD) && reg_wdata[0];
      if (wr_at(`A_STALL_SEL)) stall_sel_q <= reg_wdata[3:0];
      if (wr_at(`A_RUN_LVL)) run_lvl_q <= reg_wdata[7:0];
      if (wr_at(`A_RUN_TIME)) run_time_q <= reg_wdata[6:0];
      if (wr_at(`A_OL_SEL)) ol_sel_q <= {1'b0, reg_wdata[2:0]};
      if (wr_at(`A_OL_ACT)) ol_act_q <= reg_wdata[0];
      if (wr_at(`A_AVR)) avr_off_q <= reg_wdata[0];
      if (wr_at(`A_PHASE_EN)) begin
        ipl_en_q <= reg_wdata[0];
        opl_en_q <= reg_wdata[1];
      end
      if (wr_at(`A_OT_CFG)) ot_cfg_q <= reg_wdata[3:0];
      if (wr_at(`A_LT_CFG)) lt_cfg_q <= reg_wdata[3:0];
      if (wr_at(`A_OT_LVL)) ot_lvl_q <= reg_wdata[8:0];
      if (wr_at(`A_LT_LVL)) lt_lvl_q <= reg_wdata[8:0];
      if (wr_at(`A_OT_TIME)) ot_time_q <= reg_wdata[6:0];
      if (wr_at(`A_LT_TIME)) lt_time_q <= reg_wdata[6:0];
      if (wr_at(`A_RELAY_FN)) begin
        rly1_fn_q <= reg_wdata[4:0];
        rly2_fn_q <= reg_wdata[12:8];
      end
      if (wr_at(`A_CTRL_MODE)) mode_q <= ctrl_mode_t'(reg_wdata[1:0]);
    end
  end

  // read data stand one cycle, zero otherwise
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else begin
      unique case (reg_addr)
        `A_STALL_SEL: reg_rdata <= {12'h000, stall_sel_q};
        `A_DEC_LVL: reg_rdata <= {6'h00, dec_lvl_q};
        `A_RUN_LVL: reg_rdata <= {8'h00, run_lvl_q};
        `A_RUN_TIME: reg_rdata <= {9'h000, run_time_q};
        `A_OL_SEL: reg_rdata <= {12'h000, ol_sel_q};
        `A_OL_ACT: reg_rdata <= {15'h0000, ol_act_q};
        `A_AVR: reg_rdata <= {15'h0000, avr_off_q};
        `A_PHASE_EN: reg_rdata <= {14'h0000, opl_en_q, ipl_en_q};
        `A_OT_CFG: reg_rdata <= {12'h000, ot_cfg_q};
        `A_OT_LVL: reg_rdata <= {7'h00, ot_lvl_q};
        `A_OT_TIME: reg_rdata <= {9'h000, ot_time_q};
        `A_LT_CFG: reg_rdata <= {12'h000, lt_cfg_q};
        `A_LT_LVL: reg_rdata <= {7'h00, lt_lvl_q};
        `A_LT_TIME: reg_rdata <= {9'h000, lt_time_q};
        `A_RELAY_FN: reg_rdata <= {3'h0, rly2_fn_q, 3'h0, rly1_fn_q};
        `A_CTRL_MODE: reg_rdata <= {14'h0000, mode_q};
        `A_STATUS: reg_rdata <= {5'h00, lt_det, ot_det, warn_q, fault_contact_q,
          output_phase_loss_fault_q, input_phase_loss_fault_q,
          motor_overload_fault_q, out_block_q, ramp_reduce_q, ramp_hold_q,
          coast_stop_q};
        `A_THERMAL: reg_rdata <= th_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // reset terminal and millisecond tick
  // ----------------------------------------
  logic [2:0] xr_q;
  logic xr_stable_q, ext_rst_q, fault_reset;
  logic [16:0] pre_q;
  logic ms_tick_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      xr_q <= 3'h7;
      xr_stable_q <= 1'b1;
      ext_rst_q <= 1'b0;
    end else begin
      xr_q <= {xr_q[1:0], ext_reset_n};
      if (xr_q[1] == xr_q[2]) xr_stable_q <= xr_q[2];
      ext_rst_q <= xr_stable_q && xr_q[1] == xr_q[2] && !xr_q[2];
    end
  end
  assign fault_reset = sw_reset_q || ext_rst_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 17'h00000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= pre_q == 17'(MS_CYC - 1);
      pre_q <= (pre_q == 17'(MS_CYC - 1)) ? 17'h00000 : pre_q + 17'h00001;
    end
  end

  // ----------------------------------------
  // stall prevention
  // ----------------------------------------
  logic vf_ctrl, run_stall_on;
  logic [7:0] run_cnt_q;
  run_st_t rs_q;

  assign vf_ctrl = mode_q == vf_mode || mode_q == vf_encoder_feedback;
  assign run_stall_on = !stall_sel_q[`SS_RUN_OFF] && vf_ctrl && running;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ramp_hold_q <= 1'b0;
    end else begin
      ramp_hold_q <= decelerating && !stall_sel_q[`SS_DEC_OFF] && bus_volt > dec_lvl_q;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rs_q <= rs_idle;
      run_cnt_q <= 8'h00;
      ramp_reduce_q <= 1'b0;
      use_decel2_q <= 1'b0;
    end else begin
      use_decel2_q <= stall_sel_q[`SS_RUN_DEC2];
      unique case (rs_q)
        rs_idle: begin
          run_cnt_q <= 8'h00;
          if (run_stall_on && {1'b0, cur_pct} > {2'b00, run_lvl_q}) rs_q <= rs_timing;
        end
        rs_timing: begin
          if (!run_stall_on || {1'b0, cur_pct} <= {2'b00, run_lvl_q}) begin
            rs_q <= rs_idle;
          end else if ({1'b0, run_cnt_q} >= {2'b00, run_time_q}) begin
            rs_q <= rs_reduce;
            ramp_reduce_q <= 1'b1;
          end else if (ms_tick_q) begin
            run_cnt_q <= run_cnt_q + 8'h01;
          end
        end
        rs_reduce: begin
          if (!run_stall_on ||
              {1'b0, cur_pct} + {2'b00, `RUN_HYST_PCT} <= {2'b00, run_lvl_q}) begin
            rs_q <= rs_idle;
            ramp_reduce_q <= 1'b0;
          end
        end
        default: begin
          rs_q <= rs_idle;
          ramp_reduce_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // motor overload and voltage regulation
  // ----------------------------------------
  logic ol_trip, ol_over;
  logic [15:0] th_lim;

  assign ol_over = cur_pct > `OL_PICK_PCT;
  assign th_lim = ol_sel_q[`OLS_HOT] ? `OL_TH_HOT : `OL_TH_COLD;
  assign ol_trip = ol_sel_q[`OLS_EN] && th_q >= th_lim;

  // accumulator clears only at power-up; standard motors heat faster at low speed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      th_q <= 16'h0000;
    end else if (ms_tick_q) begin
      if (ol_over && th_q < 16'hfffd) begin
        th_q <= th_q + ((!ol_sel_q[`OLS_INV] && low_speed) ? 16'h0002 : 16'h0001);
      end else if (!ol_over && th_q != 16'h0000) begin
        th_q <= th_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      motor_overload_fault_q <= 1'b0;
      output_voltage_regulation_q <= 1'b1;
    end else begin
      output_voltage_regulation_q <= !avr_off_q;
      // warn mode lets go as soon as current is low, even while still hot
      if (ol_trip && (!ol_act_q || cur_pct >= `OL_REL_PCT)) begin
        motor_overload_fault_q <= 1'b1;
      end else if (!ol_act_q && fault_reset) begin
        motor_overload_fault_q <= 1'b0;
      end else if (ol_act_q && cur_pct < `OL_REL_PCT) begin
        motor_overload_fault_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // phase loss and torque detection
  // ----------------------------------------
  logic ipl_hit, opl_hit, vec_mode;
  logic [8:0] tq_meas;

  assign ipl_hit = ipl_en_q && in_phase_lost && cur_pct >= `IPL_MIN_PCT;
  assign opl_hit = opl_en_q && out_phase_lost && cur_pct >= `OPL_MIN_PCT;
  assign vec_mode = !vf_ctrl;
  assign tq_meas = vec_mode ? trq_pct : cur_pct;

  torque_detect u_over (
    .mclk(mclk), .resetn(resetn), .ms_tick(ms_tick_q), .running(running),
    .at_freq(at_freq), .under(1'b0), .sel(ot_cfg_q[1:0]), .level(ot_lvl_q),
    .tenths(ot_time_q), .meas(tq_meas), .det_q(ot_det)
  );
  torque_detect u_low (
    .mclk(mclk), .resetn(resetn), .ms_tick(ms_tick_q), .running(running),
    .at_freq(at_freq), .under(1'b1), .sel(lt_cfg_q[1:0]), .level(lt_lvl_q),
    .tenths(lt_time_q), .meas(tq_meas), .det_q(lt_det)
  );

  logic ot_coast, ot_decel, lt_coast, lt_decel, tq_warn;
  assign ot_coast = ot_det && ot_cfg_q[3:2] == act_coast;
  assign ot_decel = ot_det && ot_cfg_q[3:2] == act_decel;
  assign lt_coast = lt_det && lt_cfg_q[3:2] == act_coast;
  assign lt_decel = lt_det && lt_cfg_q[3:2] == act_decel;
  assign tq_warn = (ot_det && ot_cfg_q[3:2] == act_warn) || (lt_det && lt_cfg_q[3:2] == act_warn);

  // latched trips: a new event wins over a simultaneous reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      input_phase_loss_fault_q <= 1'b0;
      output_phase_loss_fault_q <= 1'b0;
      coast_stop_q <= 1'b0;
      decel_stop_q <= 1'b0;
    end else begin
      input_phase_loss_fault_q <= ipl_hit || (input_phase_loss_fault_q && !fault_reset);
      output_phase_loss_fault_q <= opl_hit || (output_phase_loss_fault_q && !fault_reset);
      coast_stop_q <= ipl_hit || opl_hit || ot_coast || lt_coast ||
        (coast_stop_q && !fault_reset);
      decel_stop_q <= ot_decel || lt_decel || (decel_stop_q && !fault_reset);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_block_q <= 1'b0;
      fault_contact_q <= 1'b0;
      warn_q <= 1'b0;
      relay1_q <= 1'b0;
      relay2_q <= 1'b0;
    end else begin
      out_block_q <= (ol_trip && !ol_act_q) || (out_block_q && !fault_reset);
      fault_contact_q <= ipl_hit || opl_hit || (ol_trip && !ol_act_q) ||
        (fault_contact_q && !fault_reset);
      warn_q <= tq_warn || (motor_overload_fault_q && ol_act_q);
      relay1_q <= relay_fn(rly1_fn_q, ot_det, lt_det);
      relay2_q <= relay_fn(rly2_fn_q, ot_det, lt_det);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence over_dec_s;
    decelerating && !stall_sel_q[`SS_DEC_OFF] && bus_volt > dec_lvl_q;
  endsequence
  dec_hold_a: assert property (over_dec_s |=> ramp_hold_q)
    else $error("ramp not held over deceleration stall level");
  dec_release_a: assert property (ramp_hold_q |-> $past(bus_volt) > $past(dec_lvl_q))
    else $error("ramp held below deceleration stall level");
  vector_no_stall_a: assert property (!vf_ctrl |=> ##1 !ramp_reduce_q)
    else $error("running stall active in vector mode");
  sequence reduce_exit_s;
    rs_q == rs_reduce && run_stall_on && {1'b0, cur_pct} + 10'h002 <= {2'b00, run_lvl_q};
  endsequence
  reduce_end_a: assert property (reduce_exit_s |=> !ramp_reduce_q)
    else $error("frequency reduction kept below release level");
  ol_block_a: assert property (ol_trip && !ol_act_q |=> out_block_q && motor_overload_fault_q)
    else $error("overload stop did not block output");
  ol_run_a: assert property (ol_trip && ol_act_q && cur_pct >= 9'h064 |=>
    !$rose(out_block_q) && motor_overload_fault_q)
    else $error("overload warning blocked output");
  ol_release_a: assert property (ol_act_q && cur_pct < 9'h064 |=> !motor_overload_fault_q)
    else $error("overload warning kept after current dropped");
  ipl_low_a: assert property (cur_pct < 9'h01e && !input_phase_loss_fault_q |=> !input_phase_loss_fault_q)
    else $error("input phase loss tripped below thirty percent");
  opl_trip_a: assert property (opl_hit |=> output_phase_loss_fault_q && coast_stop_q && fault_contact_q)
    else $error("output phase loss did not trip");
  opl_low_a: assert property (cur_pct < 9'h00a && !output_phase_loss_fault_q |=> !output_phase_loss_fault_q)
    else $error("output phase loss tripped below ten percent");
  avr_map_a: assert property ($changed(avr_off_q) |=> output_voltage_regulation_q == !$past(avr_off_q))
    else $error("regulation output does not follow setting");
  relay_map_a: assert property (rly1_fn_q == 5'h0c && ot_det |=> relay1_q)
    else $error("relay did not show over-torque");
endmodule : prot_supervisor
`default_nettype wire

// ==== tb/far_model.sv ====
// far-side model: frequency ramp state and measurement path
// assumes the bench sets its fields by hierarchical assignment
`timescale 1ns/1ps
`default_nettype none
module far_model (
  // fault feedback
  input wire logic coast_stop_q,
  // measurements and ramp state
  output logic [9:0] bus_volt,
  output logic [8:0] cur_pct,
  output logic [8:0] trq_pct,
  output logic running,
  output logic decelerating,
  output logic at_freq,
  output logic low_speed,
  output logic in_phase_lost,
  output logic out_phase_lost
);
  logic run_q = 1'b0;
  initial {bus_volt, cur_pct, trq_pct, decelerating, at_freq, low_speed} = '0;
  initial {in_phase_lost, out_phase_lost} = 2'h0;
  // a coasting motor stops running
  assign running = run_q & ~coast_stop_q;
endmodule : far_model
`default_nettype wire

// ==== tb/tb.sv ====
// bench of the protection supervisor: register tasks and protection scenarios
// assumes MS_CYC of 10, so one millisecond is ten clocks
`timescale 1ns/1ps
`default_nettype none
`include "prot_defs.svh"
module tb;
  logic mclk;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [9:0] bus_volt;
  logic [8:0] cur_pct, trq_pct;
  logic running, decelerating, at_freq, low_speed, in_phase_lost, out_phase_lost;
  logic ramp_hold_q, ramp_reduce_q, use_decel2_q, coast_stop_q, fault_contact_q, warn_q;
  logic input_phase_loss_fault_q, output_voltage_regulation_q, relay1_q;
  logic output_phase_loss_fault_q, decel_stop_q, relay2_q;
  logic ext_reset_n = 1'b1;
  int mismatches = 0;
  int tests_run = 0;
  prot_supervisor #(.MS_CYC(10)) i_prot_supervisor (.mclk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .strap_400v(1'b1), .strap_vin_hi(1'b1), .strap_big(1'b0),
    .ext_reset_n, .bus_volt, .cur_pct, .trq_pct, .running, .decelerating, .at_freq,
    .low_speed, .in_phase_lost, .out_phase_lost, .ramp_hold_q, .ramp_reduce_q, .use_decel2_q,
    .out_block_q(), .coast_stop_q, .decel_stop_q, .fault_contact_q, .warn_q,
    .motor_overload_fault_q(), .input_phase_loss_fault_q, .output_phase_loss_fault_q,
    .output_voltage_regulation_q, .relay1_q, .relay2_q);
  far_model i_far_model (.coast_stop_q, .bus_volt, .cur_pct, .trq_pct, .running,
    .decelerating, .at_freq, .low_speed, .in_phase_lost, .out_phase_lost);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // watchdog: whole run needs under 3000 clocks
  initial begin
    cyc(5000);
    mismatches++;
    report_and_stop();
  end
  initial begin
    cyc(8);
    resetn <= 1'b1;
    cyc(2);
    #1 chk(output_voltage_regulation_q, 1'b1);
    rd(`A_DEC_LVL, 16'h0316);
    rd(`A_OL_SEL, 16'h0001);
    wr(`A_OL_SEL, 16'h000f);
    rd(`A_OL_SEL, 16'h0007);
    wr(`A_AVR, 16'h0001);
    cyc(2);
    #1 chk(output_voltage_regulation_q, 1'b0);
    cyc(1);
    i_far_model.decelerating <= 1'b1;
    i_far_model.bus_volt <= 10'h317;
    cyc(3);
    #1 chk(ramp_hold_q, 1'b1);
    cyc(1);
    i_far_model.bus_volt <= 10'h30c;
    cyc(3);
    #1 chk(ramp_hold_q, 1'b0);
    wr(`A_STALL_SEL, 16'h0002);
    i_far_model.bus_volt <= 10'h317;
    cyc(3);
    #1 chk(ramp_hold_q, 1'b0);
    wr(`A_STALL_SEL, 16'h0008);
    wr(`A_RUN_TIME, 16'h0003);
    i_far_model.decelerating <= 1'b0;
    i_far_model.run_q <= 1'b1;
    i_far_model.cur_pct <= 9'h097;
    cyc(15);
    #1 chk({use_decel2_q, ramp_reduce_q}, 2'h2);
    cyc(40);
    #1 chk(ramp_reduce_q, 1'b1);
    cyc(1);
    i_far_model.cur_pct <= 9'h095;
    cyc(3);
    #1 chk(ramp_reduce_q, 1'b1);
    cyc(1);
    i_far_model.cur_pct <= 9'h094;
    cyc(3);
    #1 chk(ramp_reduce_q, 1'b0);
    wr(`A_CTRL_MODE, 16'h0002);
    i_far_model.cur_pct <= 9'h097;
    cyc(60);
    #1 chk(ramp_reduce_q, 1'b0);
    wr(`A_CTRL_MODE, 16'h0000);
    i_far_model.cur_pct <= 9'h01d;
    i_far_model.in_phase_lost <= 1'b1;
    cyc(5);
    #1 chk(input_phase_loss_fault_q, 1'b0);
    cyc(1);
    i_far_model.cur_pct <= 9'h01e;
    cyc(3);
    #1 chk({input_phase_loss_fault_q, fault_contact_q, coast_stop_q}, 3'h7);
    cyc(1);
    i_far_model.in_phase_lost <= 1'b0;
    wr(`A_CMD, 16'h0001);
    cyc(3);
    #1 chk({input_phase_loss_fault_q, coast_stop_q}, 2'h0);
    cyc(1);
    i_far_model.cur_pct <= 9'h009;
    i_far_model.out_phase_lost <= 1'b1;
    cyc(5);
    #1 chk(output_phase_loss_fault_q, 1'b0);
    cyc(1);
    i_far_model.cur_pct <= 9'h00a;
    cyc(3);
    #1 chk({output_phase_loss_fault_q, fault_contact_q, coast_stop_q}, 3'h7);
    rd(`A_STATUS, 16'h00c1);
    cyc(1);
    i_far_model.out_phase_lost <= 1'b0;
    ext_reset_n <= 1'b0;
    cyc(8);
    #1 chk({output_phase_loss_fault_q, fault_contact_q, coast_stop_q}, 3'h0);
    cyc(1);
    ext_reset_n <= 1'b1;
    wr(`A_RELAY_FN, 16'h190c);
    wr(`A_OT_CFG, 16'h0006);
    i_far_model.cur_pct <= 9'h0c8;
    cyc(900);
    #1 chk({warn_q, relay1_q}, 2'h0);
    cyc(250);
    #1 chk({warn_q, relay1_q}, 2'h3);
    wr(`A_LT_CFG, 16'h0002);
    i_far_model.cur_pct <= 9'h014;
    cyc(900);
    #1 chk({decel_stop_q, relay2_q}, 2'h0);
    cyc(250);
    #1 chk({decel_stop_q, relay2_q}, 2'h3);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
